// file: ufc_pkg.sv
package ufc_pkg;
   // ==================================================
   // Register offsets (byte address on the local port)
   localparam logic [3:0] ADDR_STAT_CTL = 4'h2;
   localparam logic [3:0] ADDR_FMT = 4'h3;
   localparam logic [3:0] ADDR_TBL = 4'h8;
   localparam logic [3:0] ADDR_ENH = 4'h9;
   localparam logic [3:0] ADDR_FLOW = 4'hA;
   localparam logic [3:0] ADDR_RXPROG = 4'hB;
   localparam logic [3:0] ADDR_TXPROG = 4'hC;
   // ==================================================
   // Field positions
   localparam int FC_EN = 0;
   localparam int FC_RXRST = 1;
   localparam int FC_TXRST = 2;
   localparam int FC_BLK = 3;
   localparam int ENH_BIT = 4;
   localparam int FMT_STOP = 2;
   localparam int FMT_PEN = 3;
   localparam int FMT_EVEN = 4;
   localparam int FMT_FORCE = 5;
   localparam int FMT_BRK = 6;
   localparam int FMT_DLAB = 7;
   // ==================================================
   // Reset values
   localparam logic [7:0] FMT_RST = 8'h00;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [6:0] PROG_RST = 7'h01;
   // ==================================================
   // Interrupt source codes, bits 5:0 of the status byte
   localparam logic [5:0] SRC_LINE = 6'h06;
   localparam logic [5:0] SRC_RXDATA = 6'h04;
   localparam logic [5:0] SRC_RXTO = 6'h0C;
   localparam logic [5:0] SRC_TXEMPTY = 6'h02;
   localparam logic [5:0] SRC_MODEM = 6'h00;
   localparam logic [5:0] SRC_FLOWCH = 6'h10;
   localparam logic [5:0] SRC_FLOW = 6'h20;
   localparam logic [5:0] SRC_NONE = 6'h01;
   // Fixed trigger levels of tables A to C, by table then select code
   localparam logic [7:0] RX_TRIG [3][4] = '{'{8'h01, 8'h04, 8'h08, 8'h0E},
      '{8'h08, 8'h10, 8'h18, 8'h1C}, '{8'h08, 8'h10, 8'h38, 8'h3C}};
   localparam logic [7:0] TX_TRIG [3][4] = '{'{8'h01, 8'h01, 8'h01, 8'h01},
      '{8'h10, 8'h08, 8'h18, 8'h1E}, '{8'h08, 8'h10, 8'h20, 8'h38}};
   // Trigger tables selected by the trigger table register bits 7:6
   typedef enum logic [1:0] {
      TBL_A = 2'b00,
      TBL_B = 2'b01,
      TBL_C = 2'b10,
      TBL_D = 2'b11
   } ufc_table_type;
   // Serial format handed to the shifters
   typedef struct packed {
      logic [3:0] wordBits;
      logic [2:0] stopHalves;
      logic parityEn;
      logic parityEven;
      logic parityForced;
      logic parityValue;
   } ufc_format_type;
endpackage

// file: ufc_line_control.sv
// Overview of operation
// - Status bits 3:1 encode interrupt source
// - Bit 4 flags flow or special char
// - Remember last flow character, Xon or Xoff
// - Bit 5 flags CTS or RTS rising
// - Bits 7:6 mirror FIFO enable
// - Bit 0 enables FIFOs, gates other bits
// - Bit 1 pulses RX FIFO reset
// - Bit 2 pulses TX FIFO reset
// - Block mode bit stored, no effect
// - TX trigger select writable only when enhanced
// - TX interrupt below trigger or empty
// - One trigger table shared by both
// - Table A levels 1,4,8,14; TX 1
// - Tables B and C fixed levels
// - Table D uses programmed levels
// - Word length 5 to 8 bits
// - One, one-and-half or two stops
// - Parity enable for TX and RX
// - Odd or even parity select
// - Forced parity mark or space
// - Break holds TX low
// - Divisor latch access select
// - RX interrupt at or above trigger; any byte with FIFOs off
//
// Added by the designer: the address-and-strobe port and the address map.
module ufc_line_control
   import ufc_pkg::*;
#(
   parameter int LVLW = 7
)
(
   input wire logic mclk,
   input wire logic reset,
   // Register port
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   // Events from the rest of the channel, same clock
   input wire logic [LVLW-1:0] rxLevel,
   input wire logic [LVLW-1:0] txLevel,
   input wire logic lineStatusEvt,
   input wire logic rxTimeoutEvt,
   input wire logic modemEvt,
   input wire logic xoffRxEvt,
   input wire logic xonRxEvt,
   input wire logic specialRxEvt,
   input wire logic rxCharDone,
   input wire logic modemStatusRead,
   input wire logic rtsOutN,
   // Pin, asynchronous
   input wire logic ctsInN,
   // Serial data from the transmit shifter
   input wire logic txShiftOut,
   output logic txPin,
   // Controls to the FIFOs and shifters
   output logic fifoEnable,
   output logic rxFifoReset,
   output logic txFifoReset,
   output logic [LVLW-1:0] rxTrigger,
   output logic [LVLW-1:0] txTrigger,
   output logic rxDataIrq,
   output logic txReadyIrq,
   output logic irqPending,
   output ufc_format_type lineFormat,
   output logic divisorSelect,
   output logic dataSelect
);

   // ==================================================
   // Registers
   logic [7:0] fmt_q; // Serial format control
   logic [7:0] enh_q; // Enhanced feature register
   logic [7:0] tbl_q; // Trigger table register
   logic fifoEn_q; // FIFO enable
   logic blockMode_q; // Legacy block mode, no function
   logic [1:0] rxSel_q; // RX trigger select
   logic [1:0] txSel_q; // TX trigger select
   logic [LVLW-1:0] rxProg_q; // Table D RX level
   logic [LVLW-1:0] txProg_q; // Table D TX level
   logic rxRst_q; // RX FIFO reset pulse
   logic txRst_q; // TX FIFO reset pulse
   logic xFlowFlag_q; // Xon or Xoff seen
   logic specialFlag_q; // Special character seen
   logic xoffLast_q; // Last flow char was Xoff
   logic xonLast_q; // Last flow char was Xon
   logic flowFlag_q; // CTS or RTS went high
   logic ctsMeta_q; // Synchroniser stage one
   logic ctsSync_q; // Synchroniser stage two
   logic ctsPrev_q; // Previous synced CTS
   logic rtsPrev_q; // Previous RTS
   logic txIrq_q; // TX ready pending
   logic filledAbove_q; // Last reload passed trigger
   logic [LVLW-1:0] txPrev_q; // TX level one cycle ago
   logic [7:0] rdData_q; // Read data register
   logic [7:0] statusValue; // Live status byte
   logic statusRead; // Status read strobe
   logic fifoCtlWrite; // FIFO control write strobe
   ufc_table_type table_s; // Active trigger table
   // Trigger level lookup; table D takes the programmed level
   function automatic logic [LVLW-1:0] trigLevel(
      input ufc_table_type tbl,
      input logic [1:0] sel,
      input logic isTx,
      input logic [LVLW-1:0] prog);
      logic [7:0] v;
      if (tbl == TBL_D)
         v = {{(8-LVLW){1'b0}}, prog};
      else if (isTx)
         v = TX_TRIG[tbl][sel];
      else
         v = RX_TRIG[tbl][sel];
      return v[LVLW-1:0];
   endfunction
   assign statusRead = regRd && (regAddr == ADDR_STAT_CTL);
   assign fifoCtlWrite = regWr && (regAddr == ADDR_STAT_CTL);
   assign table_s = ufc_table_type'(tbl_q[7:6]);
   // ==================================================
   // Plain registers written by software
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         fmt_q <= FMT_RST;
         enh_q <= REG_RST;
         tbl_q <= REG_RST;
         rxProg_q <= PROG_RST;
         txProg_q <= PROG_RST;
      end
      else if (regWr)
         case (regAddr)
            ADDR_FMT: fmt_q <= regWrData;
            ADDR_ENH: enh_q <= regWrData;
            ADDR_TBL: tbl_q <= regWrData;
            ADDR_RXPROG: rxProg_q <= regWrData[LVLW-1:0];
            ADDR_TXPROG: txProg_q <= regWrData[LVLW-1:0];
            default: ;
         endcase
   end
   // ==================================================
   // FIFO control; other bits count only with bit 0 set.
   // Reset pulses last one cycle and are not stored; reads of this address return the status byte
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         fifoEn_q <= 1'b0;
         blockMode_q <= 1'b0;
         rxSel_q <= 2'b00;
         txSel_q <= 2'b00;
         rxRst_q <= 1'b0;
         txRst_q <= 1'b0;
      end
      else
      begin
         rxRst_q <= fifoCtlWrite && regWrData[FC_EN] && regWrData[FC_RXRST];
         txRst_q <= fifoCtlWrite && regWrData[FC_EN] && regWrData[FC_TXRST];
         if (fifoCtlWrite)
         begin
            fifoEn_q <= regWrData[FC_EN];
            if (regWrData[FC_EN])
            begin
               blockMode_q <= regWrData[FC_BLK];
               rxSel_q <= regWrData[7:6];
               if (enh_q[ENH_BIT])
                  txSel_q <= regWrData[5:4];
            end
         end
      end
   end

   // ==================================================
   // Flow and special character flags; a new event beats a clear
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         xFlowFlag_q <= 1'b0;
         specialFlag_q <= 1'b0;
         xoffLast_q <= 1'b0;
         xonLast_q <= 1'b0;
      end
      else
      begin
         if (xoffRxEvt || xonRxEvt)
            xFlowFlag_q <= 1'b1;
         else if (statusRead)
            xFlowFlag_q <= 1'b0;
         if (specialRxEvt)
            specialFlag_q <= 1'b1;
         else if (statusRead || rxCharDone)
            specialFlag_q <= 1'b0;
         if (xoffRxEvt)
         begin
            xoffLast_q <= 1'b1;
            xonLast_q <= 1'b0;
         end
         else if (xonRxEvt)
         begin
            xoffLast_q <= 1'b0;
            xonLast_q <= 1'b1;
         end
      end
   end

   // ==================================================
   // CTS pin synchroniser and rising edge flag
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         ctsMeta_q <= 1'b0;
         ctsSync_q <= 1'b0;
         ctsPrev_q <= 1'b0;
         rtsPrev_q <= 1'b0;
         flowFlag_q <= 1'b0;
      end
      else
      begin
         ctsMeta_q <= ctsInN;
         ctsSync_q <= ctsMeta_q;
         ctsPrev_q <= ctsSync_q;
         rtsPrev_q <= rtsOutN;
         // Cleared by a modem status read elsewhere in the channel
         if ((ctsSync_q && !ctsPrev_q) || (rtsOutN && !rtsPrev_q))
            flowFlag_q <= 1'b1;
         else if (modemStatusRead)
            flowFlag_q <= 1'b0;
      end
   end

   // ==================================================
   // TX ready interrupt: falling through the trigger, or
   // emptying after a reload that never passed it
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         txPrev_q <= '0;
         filledAbove_q <= 1'b0;
         txIrq_q <= 1'b0;
      end
      else
      begin
         txPrev_q <= txLevel;
         if (txLevel > txTrigger)
            filledAbove_q <= 1'b1;
         else if (txLevel == '0)
            filledAbove_q <= 1'b0;
         if ((txPrev_q >= txTrigger && txLevel < txTrigger) ||
             (txPrev_q != '0 && txLevel == '0 && !filledAbove_q))
            txIrq_q <= 1'b1;
         else if (statusRead)
            txIrq_q <= 1'b0;
      end
   end
   // ==================================================
   // Trigger levels, RX interrupt and status byte
   always_comb
   begin
      rxTrigger = trigLevel(table_s, rxSel_q, 1'b0, rxProg_q);
      txTrigger = trigLevel(table_s, txSel_q, 1'b1, txProg_q);
      // Without FIFOs one byte is enough to interrupt
      rxDataIrq = fifoEn_q ? (rxLevel >= rxTrigger) : (rxLevel != '0);
   end

   // Highest priority pending source wins
   always_comb
   begin
      statusValue = {fifoEn_q, fifoEn_q, SRC_NONE};
      if (lineStatusEvt)
         statusValue[5:0] = SRC_LINE;
      else if (rxDataIrq)
         statusValue[5:0] = SRC_RXDATA;
      else if (rxTimeoutEvt)
         statusValue[5:0] = SRC_RXTO;
      else if (txIrq_q)
         statusValue[5:0] = SRC_TXEMPTY;
      else if (modemEvt)
         statusValue[5:0] = SRC_MODEM;
      else if (enh_q[ENH_BIT] && (xFlowFlag_q || specialFlag_q))
         statusValue[5:0] = SRC_FLOWCH;
      else if (enh_q[ENH_BIT] && flowFlag_q)
         statusValue[5:0] = SRC_FLOW;
   end
   // ==================================================
   // Read data, one cycle after the strobe; holes read zero
   always_ff @(posedge mclk)
   begin
      if (reset || !regRd)
         rdData_q <= REG_RST;
      else
         case (regAddr)
            ADDR_STAT_CTL: rdData_q <= statusValue;
            ADDR_FMT: rdData_q <= fmt_q;
            ADDR_TBL: rdData_q <= tbl_q;
            ADDR_ENH: rdData_q <= enh_q;
            ADDR_FLOW: rdData_q <= {6'b00_0000, xonLast_q, xoffLast_q};
            ADDR_RXPROG: rdData_q <= {{(8-LVLW){1'b0}}, rxProg_q};
            ADDR_TXPROG: rdData_q <= {{(8-LVLW){1'b0}}, txProg_q};
            default: rdData_q <= REG_RST;
         endcase
   end
   // ==================================================
   // Outputs
   always_comb
   begin
      lineFormat.wordBits = 4'h5 + {2'b00, fmt_q[1:0]};
      // Stop length in half bits: 2, 3 for 5-bit words, else 4
      if (!fmt_q[FMT_STOP])
         lineFormat.stopHalves = 3'h2;
      else if (fmt_q[1:0] == 2'b00)
         lineFormat.stopHalves = 3'h3;
      else
         lineFormat.stopHalves = 3'h4;
      lineFormat.parityEn = fmt_q[FMT_PEN];
      lineFormat.parityEven = fmt_q[FMT_EVEN];
      lineFormat.parityForced = fmt_q[FMT_FORCE];
      lineFormat.parityValue = !fmt_q[FMT_EVEN];
   end
   assign txPin = txShiftOut && !fmt_q[FMT_BRK];
   assign divisorSelect = fmt_q[FMT_DLAB];
   assign dataSelect = !fmt_q[FMT_DLAB];
   assign fifoEnable = fifoEn_q;
   assign rxFifoReset = rxRst_q;
   assign txFifoReset = txRst_q;
   assign txReadyIrq = txIrq_q;
   assign irqPending = !statusValue[0];
   assign regRdData = rdData_q;
   // ==================================================
   // Checks
   fifo_status_a: assert property (@(posedge mclk) disable iff (reset)
      statusValue[7:6] == {2{fifoEnable}})
      else $error("FIFO status bits wrong");
   rx_reset_a: assert property (@(posedge mclk) disable iff (reset)
      fifoCtlWrite && regWrData[FC_EN] && regWrData[FC_RXRST] |=> rxFifoReset ##1 !rxFifoReset)
      else $error("RX FIFO reset pulse wrong");
   tx_reset_a: assert property (@(posedge mclk) disable iff (reset)
      txFifoReset |-> $past(fifoCtlWrite) && $past(regWrData[FC_EN]))
      else $error("TX FIFO reset without enabled write");
   fifo_gate_a: assert property (@(posedge mclk) disable iff (reset)
      fifoCtlWrite && !regWrData[FC_EN] |=> !fifoEnable && $stable(rxSel_q))
      else $error("FIFO control bits taken while disabling");
   tx_sel_a: assert property (@(posedge mclk) disable iff (reset)
      !enh_q[ENH_BIT] |=> $stable(txSel_q))
      else $error("TX trigger changed without enhanced mode");
   table_a_a: assert property (@(posedge mclk) disable iff (reset)
      table_s == TBL_A |-> txTrigger == 7'd1)
      else $error("Table A TX trigger not one");
   break_a: assert property (@(posedge mclk) disable iff (reset)
      fmt_q[FMT_BRK] |-> !txPin)
      else $error("Break not holding TX low");
   special_clr_a: assert property (@(posedge mclk) disable iff (reset)
      specialFlag_q && rxCharDone && !specialRxEvt |=> !specialFlag_q)
      else $error("Special flag not cleared by next char");
   cts_edge_a: assert property (@(posedge mclk) disable iff (reset)
      ctsSync_q && !ctsPrev_q |=> flowFlag_q)
      else $error("CTS rise not flagged");
   rx_irq_a: assert property (@(posedge mclk) disable iff (reset)
      fifoEnable && rxLevel < rxTrigger |-> !rxDataIrq)
      else $error("RX interrupt below trigger");
   stop_a: assert property (@(posedge mclk) disable iff (reset)
      fmt_q[FMT_STOP] && fmt_q[1:0] != 2'b00 |-> lineFormat.stopHalves == 3'h4)
      else $error("Two stop bits expected");
   cover_tx_irq: cover property (@(posedge mclk) disable iff (reset) $rose(txIrq_q));
   cover_flow_char: cover property (@(posedge mclk) disable iff (reset)
      statusValue[5:0] == SRC_FLOWCH ##1 statusRead);
   cover_table_d: cover property (@(posedge mclk) disable iff (reset)
      table_s == TBL_D && rxDataIrq);
endmodule

// file: ufc_remote_line.sv
// ==================================================
// Far-end serial device: drives CTS# and watches TX
module ufc_remote_line
#(
   parameter int BRK_CYC = 16
)
(
   input wire logic mclk,
   input wire logic txPin,
   input wire logic holdOff,
   output logic ctsInN,
   output logic breakSeen
);
   timeunit 1ns;
   timeprecision 100ps;
   // Count of consecutive low samples on the line
   int lowRun = 0;
   // CTS# moves off the clock grid, since the real pin is asynchronous
   initial ctsInN = 1'b0;
   always @(holdOff)
   begin
      ctsInN <= #3 holdOff;
   end
   // A line held low for a whole character slot is a break
   always @(posedge mclk)
   begin
      if (txPin)
         lowRun <= 0;
      else
         lowRun <= lowRun + 1;
   end
   assign breakSeen = (lowRun >= BRK_CYC);
endmodule

// file: uart_fifo_line_control_bench.sv
module uart_fifo_line_control_bench
   import ufc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ==================================================
   // Stimulus and observed signals
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWrData = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regRdData;
   logic [6:0] rxLevel = 7'h00;
   logic [6:0] txLevel = 7'h00;
   // Level events: line status, timeout, modem
   logic [2:0] lvlEvt = 3'h0;
   // Pulses: xoff, xon, special, char done, modem status read
   logic [4:0] pls = 5'h00;
   logic rtsOutN = 1'b0;
   logic holdOff = 1'b0;
   logic ctsInN, txShiftOut = 1'b1, txPin, breakSeen;
   logic fifoEnable, rxFifoReset, txFifoReset, rxDataIrq, txReadyIrq, irqPending;
   logic divisorSelect, dataSelect;
   logic [6:0] rxTrigger, txTrigger;
   ufc_format_type lineFormat;
   int nMismatch = 0;
   int totalChecks = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h8e0a_936c;
   logic [7:0] v;
   logic [31:0] rn;
   logic [6:0] pr;
   // Reference trigger tables A, B, C
   int rxT[3][4] = '{'{1, 4, 8, 14}, '{8, 16, 24, 28}, '{8, 16, 56, 60}};
   int txT[3][4] = '{'{1, 1, 1, 1}, '{16, 8, 24, 30}, '{8, 16, 32, 56}};
   // Status values for single sources, FIFOs on
   logic [7:0] srcQ[$] = '{8'hC6, 8'hCC, 8'hC0};
   // ==================================================
   // Clock and watchdog
   initial
   begin
      forever #4 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         nMismatch++;
         wrap_up();
      end
   end
   // ==================================================
   // Design and far end
   ufc_line_control uut (.mclk(mclk), .reset(reset), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .rxLevel(rxLevel), .txLevel(txLevel), .lineStatusEvt(lvlEvt[2]),
      .rxTimeoutEvt(lvlEvt[1]), .modemEvt(lvlEvt[0]), .xoffRxEvt(pls[0]),
      .xonRxEvt(pls[1]), .specialRxEvt(pls[2]), .rxCharDone(pls[3]),
      .modemStatusRead(pls[4]), .rtsOutN(rtsOutN), .ctsInN(ctsInN),
      .txShiftOut(txShiftOut), .txPin(txPin), .fifoEnable(fifoEnable),
      .rxFifoReset(rxFifoReset), .txFifoReset(txFifoReset), .rxTrigger(rxTrigger),
      .txTrigger(txTrigger), .rxDataIrq(rxDataIrq), .txReadyIrq(txReadyIrq),
      .irqPending(irqPending), .lineFormat(lineFormat),
      .divisorSelect(divisorSelect), .dataSelect(dataSelect));
   ufc_remote_line far (.mclk(mclk), .txPin(txPin), .holdOff(holdOff),
      .ctsInN(ctsInN), .breakSeen(breakSeen));
   // ==================================================
   // Compare tasks, one per kind of result
   task automatic note(input bit ok, input string m);
      totalChecks++;
      if (!ok)
      begin
         nMismatch++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic chkByte(input logic [7:0] g, input logic [7:0] e);
      note(g === e, $sformatf("read %h exp %h", g, e));
   endtask
   task automatic chkLvl(input logic [6:0] g, input int e);
      note(g === 7'(e), $sformatf("level %0d exp %0d", g, e));
   endtask
   task automatic chkSig(input logic g, input logic e);
      note(g === e, $sformatf("signal %b exp %b", g, e));
   endtask
   task automatic chkFmt(input ufc_format_type g, input ufc_format_type e);
      note(g === e, $sformatf("format %h exp %h", g, e));
   endtask
   // ==================================================
   // Register port cycles; each returns just after the taking edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge mclk);
      regWr <= 1'b0;
      #1;
   endtask
   task automatic rdChk(input logic [3:0] a, input logic [7:0] e);
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 chkByte(regRdData, e);
   endtask
   // One-cycle event pulse
   task automatic pulse(input int k);
      @(posedge mclk);
      pls[k] <= 1'b1;
      @(posedge mclk);
      pls <= 5'h00;
      #1;
   endtask
   // Expected serial format from a format byte
   function automatic ufc_format_type fmtOf(input logic [7:0] x);
      ufc_format_type f;
      f.wordBits = 4'h5 + 4'(x[1:0]);
      f.stopHalves = !x[2] ? 3'h2 : (x[1:0] == 2'h0 ? 3'h3 : 3'h4);
      f.parityEn = x[3];
      f.parityEven = x[4];
      f.parityForced = x[5];
      f.parityValue = !x[4];
      return f;
   endfunction
   task automatic wrap_up();
      $display("Checks %0d mismatches %0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ==================================================
   // Main sequence
   initial
   begin
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      // Reset state
      rdChk(ADDR_FMT, 8'h00);
      rdChk(ADDR_STAT_CTL, 8'h01);
      chkLvl(rxTrigger, 1);
      chkSig(fifoEnable, 1'b0);
      // Every word length, stop and parity mode, random break and divisor bits
      for (int i = 0; i < 8; i++)
      begin
         rn = $random(seed);
         v = {rn[7:6], 3'(i), 3'(i)};
         wr(ADDR_FMT, v);
         chkFmt(lineFormat, fmtOf(v));
         chkSig(divisorSelect, v[7]);
         chkSig(dataSelect, !v[7]);
         @(posedge mclk);
         txShiftOut <= rn[9];
         #1 chkSig(txPin, rn[9] & !v[6]);
         rdChk(ADDR_FMT, v);
      end
      // Break held until cleared, with the shifter idling high
      txShiftOut <= 1'b1;
      wr(ADDR_FMT, 8'h40);
      repeat (20) @(posedge mclk);
      #1 chkSig(breakSeen, 1'b1);
      wr(ADDR_FMT, 8'h03);
      repeat (2) @(posedge mclk);
      #1 chkSig(breakSeen, 1'b0);
      // FIFO enable with both resets; pulses last one cycle
      wr(ADDR_STAT_CTL, 8'h07);
      chkSig(rxFifoReset, 1'b1);
      chkSig(txFifoReset, 1'b1);
      @(posedge mclk);
      #1 chkSig(rxFifoReset | txFifoReset, 1'b0);
      rdChk(ADDR_STAT_CTL, 8'hC1);
      // Bit 0 low: other bits ignored, FIFOs off
      wr(ADDR_STAT_CTL, 8'h06);
      chkSig(rxFifoReset | txFifoReset | fifoEnable, 1'b0);
      rdChk(ADDR_STAT_CTL, 8'h01);
      // Block mode bit is accepted without side effects
      wr(ADDR_STAT_CTL, 8'h09);
      chkSig(fifoEnable, 1'b1);
      chkLvl(txTrigger, 1);
      // TX select refused without the enhanced bit
      wr(ADDR_TBL, 8'h40);
      wr(ADDR_STAT_CTL, 8'h31);
      chkLvl(txTrigger, txT[1][0]);
      wr(ADDR_ENH, 8'h10);
      // Tables A to C, every code, one table for both sides
      for (int t = 0; t < 3; t++)
      begin
         for (int c = 0; c < 4; c++)
         begin
            wr(ADDR_STAT_CTL, {2'(c), 2'(c), 4'h1});
            wr(ADDR_TBL, {2'(t), 6'h00});
            chkLvl(rxTrigger, rxT[t][c]);
            chkLvl(txTrigger, txT[t][c]);
         end
      end
      // Table D: programmed levels, select fields ignored
      pr = 7'($random(seed)) & 7'h3F | 7'h01;
      wr(ADDR_TBL, 8'hC0);
      wr(ADDR_RXPROG, {1'b0, pr});
      wr(ADDR_TXPROG, {1'b0, pr ^ 7'h0E});
      wr(ADDR_STAT_CTL, 8'hF1);
      chkLvl(rxTrigger, int'(pr));
      chkLvl(txTrigger, int'(pr ^ 7'h0E));
      // RX trigger of 8 in table A
      wr(ADDR_TBL, 8'h00);
      wr(ADDR_STAT_CTL, 8'h81);
      @(posedge mclk);
      rxLevel <= 7'h08;
      #1 chkSig(rxDataIrq, 1'b1);
      rdChk(ADDR_STAT_CTL, 8'hC4);
      @(posedge mclk);
      rxLevel <= 7'h07;
      #1 chkSig(rxDataIrq, 1'b0);
      chkSig(irqPending, 1'b0);
      // Single sources, then timeout beneath data ready
      for (int k = 0; k < 3; k++)
      begin
         @(posedge mclk);
         lvlEvt <= 3'h4 >> k;
         rdChk(ADDR_STAT_CTL, srcQ[k]);
      end
      @(posedge mclk);
      lvlEvt <= 3'h3;
      rxLevel <= 7'h08;
      rdChk(ADDR_STAT_CTL, 8'hC4);
      chkSig(irqPending, 1'b1);
      @(posedge mclk);
      lvlEvt <= 3'h0;
      rxLevel <= 7'h00;
      // Flow characters, Xoff then Xon
      for (int k = 0; k < 2; k++)
      begin
         pulse(k);
         rdChk(ADDR_STAT_CTL, 8'hD0);
         rdChk(ADDR_STAT_CTL, 8'hC1);
         rdChk(ADDR_FLOW, 8'(1 << k));
      end
      // Special match cleared by the next character, then by a status read
      pulse(2);
      pulse(3);
      rdChk(ADDR_STAT_CTL, 8'hC1);
      pulse(2);
      rdChk(ADDR_STAT_CTL, 8'hD0);
      rdChk(ADDR_STAT_CTL, 8'hC1);
      // CTS# and RTS# rising edges
      holdOff <= 1'b1;
      repeat (5) @(posedge mclk);
      rdChk(ADDR_STAT_CTL, 8'hE0);
      pulse(4);
      rtsOutN <= 1'b1;
      rdChk(ADDR_STAT_CTL, 8'hE0);
      pulse(4);
      rdChk(ADDR_STAT_CTL, 8'hC1);
      // No flow flag while enhanced mode is off
      wr(ADDR_ENH, 8'h00);
      pulse(0);
      rdChk(ADDR_STAT_CTL, 8'hC1);
      // TX interrupt: falling through trigger 16, then empty after a short reload
      wr(ADDR_TBL, 8'h40);
      wr(ADDR_STAT_CTL, 8'h01);
      foreach (srcQ[k])
      begin
         @(posedge mclk);
         txLevel <= (k == 0) ? 7'h14 : (k == 1) ? 7'h0F : 7'h00;
         repeat (2) @(posedge mclk);
         #1 chkSig(txReadyIrq, k == 1);
         if (k == 1)
            rdChk(ADDR_STAT_CTL, 8'hC2);
      end
      @(posedge mclk);
      txLevel <= 7'h05;
      @(posedge mclk);
      txLevel <= 7'h00;
      repeat (2) @(posedge mclk);
      #1 chkSig(txReadyIrq, 1'b1);
      rdChk(ADDR_STAT_CTL, 8'hC2);
      #1 chkSig(txReadyIrq, 1'b0);
      wrap_up();
   end
endmodule
